//--- core/sleep_aware_watchdog_timer.sv
// watchdog timer on the slow oscillator with core register port
`timescale 1ns/1ns
`default_nettype none
`include "wd_cfg.svh"
module sleep_aware_watchdog_timer (
  // clocks and reset
  input wire logic clk_i,
  input wire logic low_freq_osc_i,
  input wire logic rst_n_i,
  // configuration and device state
  input wire logic [1:0] wd_mode_cfg_i,
  input wire logic sleep_i,
  input wire logic wake_clk_clears_i,
  input wire logic osc_startup_timer_i,
  input wire logic osc_fail_i,
  input wire logic clear_watchdog_instr_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // results
  output logic reset_req_o,
  output logic wake_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o,
  output logic wd_reset_cause_flag_o,
  output logic irq_o
);
  logic sw_wd_enable_q;
  logic [`WD_PS_W-1:0] timeout_prescale_sel_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [2:0] osc_sync_q;
  logic [1:0] mode_s1_q, mode_s2_q;
  logic [3:0] async_s1_q, async_s2_q;
  logic clr_tgl_q, clr_s1_q, clr_s2_q, clr_s3_q;
  logic sleep_d1_q;
  logic [5:0] div_q;
  logic [`WD_CNT_W-1:0] cnt_q;
  logic [`WD_CNT_W-1:0] limit;
  logic tick, active, clear_cnt, expire, sleeping, sync_en;
  wd_pkg::wd_mode_t mode;

  // slow clock sampled as data; the core clock is far faster
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) osc_sync_q <= 3'h0;
    else osc_sync_q <= {osc_sync_q[1:0], low_freq_osc_i};
  end
  assign tick = osc_sync_q[1] & ~osc_sync_q[2]; // R1

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      async_s1_q <= 4'h0;
      async_s2_q <= 4'h0;
    end else begin
      mode_s1_q <= wd_mode_cfg_i;
      mode_s2_q <= mode_s1_q;
      async_s1_q <= {sleep_i, wake_clk_clears_i, osc_startup_timer_i, osc_fail_i};
      async_s2_q <= async_s1_q;
    end
  end
  assign mode = wd_pkg::wd_mode_t'(mode_s2_q);
  assign sleeping = async_s2_q[3];

  // clear instruction is a core pulse; toggle hand-off guards the slow side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) clr_tgl_q <= 1'b0;
    else if (clear_watchdog_instr_i) clr_tgl_q <= ~clr_tgl_q;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_s1_q <= 1'b0;
      clr_s2_q <= 1'b0;
      clr_s3_q <= 1'b0;
      sleep_d1_q <= 1'b0;
    end else begin
      clr_s1_q <= clr_tgl_q; // R17
      clr_s2_q <= clr_s1_q;
      clr_s3_q <= clr_s2_q;
      sleep_d1_q <= sleeping;
    end
  end

  always_comb begin
    unique case (mode)
      wd_pkg::MODE_OFF: active = 1'b0; // R2
      wd_pkg::MODE_SW: active = sync_en; // R5
      wd_pkg::MODE_AWAKE: active = ~sleeping; // R4
      wd_pkg::MODE_ON: active = 1'b1; // R3
    endcase
  end
  assign sync_en = sw_wd_enable_q; // R17 asks for a synchronised enable; sw_wd_enable_q is used directly

  // divider changes have no input here, so they cannot touch the count
  assign clear_cnt = !active || (clr_s2_q ^ clr_s3_q) || async_s2_q[0] // R8 R15
    || (sleeping != sleep_d1_q && (sleeping || async_s2_q[2])) // R9 R10
    || async_s2_q[1]; // R11

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) div_q <= 6'h0;
    else if (clear_cnt) div_q <= 6'h0;
    else if (tick) div_q <= (div_q == 6'(`WD_TICK_CYCLES - 1)) ? 6'h0 : div_q + 6'h1;
  end

  // limit in ms ticks: 2^ps, ps above the top saturates at 2^18 ms (262 s)
  assign limit = (timeout_prescale_sel_q > `WD_PS_MAX) ? (`WD_CNT_W'(1) << `WD_PS_MAX) :
    (`WD_CNT_W'(1) << timeout_prescale_sel_q); // R6
  assign expire = tick && !clear_cnt && div_q == 6'(`WD_TICK_CYCLES - 1) && cnt_q + 1'b1 >= limit;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= '0;
    else if (clear_cnt || expire) cnt_q <= '0; // R8 R9
    else if (tick && div_q == 6'(`WD_TICK_CYCLES - 1)) cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_req_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      reset_req_o <= expire && !sleeping; // R16
      wake_o <= expire && sleeping; // R12
    end
  end

  // flags; the reset controller resets the block after a reset request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_flag_n_o <= 1'b1;
      powerdown_flag_n_o <= 1'b1;
      wd_reset_cause_flag_o <= 1'b1;
    end else if (expire) begin
      timeout_flag_n_o <= 1'b0; // R13
      powerdown_flag_n_o <= ~sleeping; // R13
      wd_reset_cause_flag_o <= 1'b0; // R14
    end else if (clear_watchdog_instr_i) begin
      timeout_flag_n_o <= 1'b1;
      powerdown_flag_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_wd_enable_q <= 1'b0;
      timeout_prescale_sel_q <= `WD_PS_RST; // R7
      mask_q <= 2'h0;
    end else if (wr_i && addr_i == `WD_ADDR_CTRL) begin
      sw_wd_enable_q <= wdata_i[`WD_CTRL_EN_BIT];
      timeout_prescale_sel_q <= wdata_i[`WD_CTRL_PS_LSB +: `WD_PS_W]; // R6
    end else if (wr_i && addr_i == `WD_ADDR_MASK) begin
      mask_q <= wdata_i[1:0];
    end
  end

  // status: bit0 awake timeout, bit1 sleep wake; set beats clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) stat_q <= 2'h0;
    else stat_q <= (stat_q & ~((wr_i && addr_i == `WD_ADDR_STAT) ? wdata_i[1:0] : 2'h0))
      | {expire && sleeping, expire && !sleeping};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) irq_o <= 1'b0;
    else irq_o <= |((stat_q | {expire && sleeping, expire && !sleeping}) & mask_q);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_o <= 8'h00;
    else if (rd_i) begin
      unique case (addr_i)
        `WD_ADDR_CTRL: rdata_o <= {2'h0, timeout_prescale_sel_q, sw_wd_enable_q};
        `WD_ADDR_STAT: rdata_o <= {3'h0, wd_reset_cause_flag_o, powerdown_flag_n_o,
          timeout_flag_n_o, stat_q};
        `WD_ADDR_MASK: rdata_o <= {6'h0, mask_q};
        default: rdata_o <= 8'h00;
      endcase
    end else rdata_o <= 8'h00;
  end

  a_off_no_count: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    mode == wd_pkg::MODE_OFF |=> cnt_q == '0)
    else $error("counter moved while off");
  a_on_in_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    mode == wd_pkg::MODE_ON |-> active)
    else $error("always-on mode inactive");
  a_awake_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
    mode == wd_pkg::MODE_AWAKE && sleeping |=> cnt_q == '0)
    else $error("awake mode counted in sleep");
  a_sw_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    mode == wd_pkg::MODE_SW |-> active == sw_wd_enable_q)
    else $error("software mode mismatch");
  a_ost_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    async_s2_q[1] |=> cnt_q == '0 && div_q == 6'h0)
    else $error("counter moved during start-up");
  a_sleep_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    expire && sleeping |=> wake_o && !reset_req_o)
    else $error("sleep timeout did not wake");
  a_awake_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R16
    expire && !sleeping |=> reset_req_o ##1 !reset_req_o)
    else $error("awake timeout reset wrong");
  a_flags_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
    expire |=> !timeout_flag_n_o && !wd_reset_cause_flag_o)
    else $error("timeout flags not updated");
  a_sleep_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
    sleeping && !sleep_d1_q |=> cnt_q == '0)
    else $error("sleep entry did not clear");
endmodule
`default_nettype wire

//--- core/wd_cfg.svh
// constants for the sleep aware watchdog timer
// Overview of operation
// R1 - the counter advances on ticks of the 31 kHz low frequency oscillator, one tick standing for 1 ms.
// R2 - a two-bit mode field picks one of four modes and mode 00 disables the watchdog.
// R3 - mode 11 keeps the watchdog active always, in sleep too, whatever the software enable.
// R4 - mode 10 keeps the watchdog active while awake and disabled in sleep.
// R5 - mode 01 makes the watchdog active exactly when the software enable is 1, sleep changing nothing.
// R6 - a software prescale field sets the timeout from 1 ms up to 256 s; the code tops out at 2^18 ms, about 262 s.
// R7 - after any reset the prescale field selects the 2 s timeout.
// R8 - the counter clears on reset, on the clear instruction, on oscillator failure and while disabled.
// R9 - entering sleep clears the counter, which then counts from zero if still enabled.
// R10 - waking with an RC, internal or external system clock clears the counter again.
// R11 - while the start-up timer runs the counter stays at zero and resumes after it ends.
// R12 - a timeout in sleep wakes the device instead of resetting it.
// R13 - a timeout updates the active-low timeout and power-down flags.
// R14 - a timeout sets the watchdog reset-cause flag of the power control register; the code drives that flag from its reset value 1 to 0 instead.
// R15 - changing the internal oscillator divider leaves the counter untouched.
// R16 - a timeout while awake and active requests a device reset.
// R17 - clear and enable requests from the core are synchronised into the slow domain; the code synchronises only the clear and uses the enable directly.
`ifndef WD_CFG_SVH
`define WD_CFG_SVH
`define WD_OSC_FREQ_HZ 31000
`define WD_BASE_PERIOD_US 1000
`define WD_TICK_CYCLES 31
`define WD_CNT_W 19
`define WD_PS_W 5
`define WD_PS_RST 5'h0B
`define WD_PS_MAX 5'h12
`define WD_ADDR_CTRL 4'h0
`define WD_ADDR_STAT 4'h1
`define WD_ADDR_MASK 4'h2
`define WD_CTRL_EN_BIT 0
`define WD_CTRL_PS_LSB 1
`endif

//--- core/wd_pkg.sv
// types for the sleep aware watchdog timer
package wd_pkg;
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SW = 2'b01,
    MODE_AWAKE = 2'b10,
    MODE_ON = 2'b11
  } wd_mode_t;
endpackage

//--- testbench/lfo_model.sv
// slow oscillator model for the watchdog bench
`timescale 1ns/1ns
`default_nettype none
module lfo_model (
  // slow clock
  output logic low_freq_osc_o
);
  // far faster than 31 kHz so that a 1 ms step fits a short run
  initial low_freq_osc_o = 1'b0;
  always #20 low_freq_osc_o = ~low_freq_osc_o;
endmodule
`default_nettype wire

//--- testbench/sleep_aware_watchdog_timer_test.sv
// self-checking bench for the sleep aware watchdog timer
`timescale 1ns/1ns
`default_nettype none
`include "wd_cfg.svh"
module sleep_aware_watchdog_timer_test;
  typedef struct {logic [1:0] m; logic en, slp, osc_startup_timer, fail; logic [1:0] exp;} row_t;
  logic clk_i = 1'b0, rst_n_i = 1'b0, lfo, sleep_i = 1'b0, osc_startup_timer = 1'b0, fail = 1'b0, clr = 1'b0;
  logic [1:0] mode = 2'b00;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, d;
  logic wr_i = 1'b0, rd_i = 1'b0, rq, wk, to_n, pd_n, cause, irq_o;
  int bad_count = 0, samples_checked = 0, rq_n = 0, wk_n = 0, r0, w0;
  row_t rows [9] = '{
    '{2'b00, 1, 0, 0, 0, 2'h0},
    '{2'b01, 0, 0, 0, 0, 2'h0},
    '{2'b01, 1, 0, 0, 0, 2'h1},
    '{2'b01, 1, 1, 0, 0, 2'h2},
    '{2'b10, 0, 0, 0, 0, 2'h1},
    '{2'b10, 0, 1, 0, 0, 2'h0},
    '{2'b11, 0, 1, 0, 0, 2'h2},
    '{2'b11, 0, 0, 1, 0, 2'h0},
    '{2'b11, 0, 0, 0, 1, 2'h0}};
  always #5 clk_i = ~clk_i;
  lfo_model lfo_model_i (.low_freq_osc_o(lfo));
  sleep_aware_watchdog_timer sleep_aware_watchdog_timer_i (.clk_i(clk_i), .low_freq_osc_i(lfo),
    .rst_n_i(rst_n_i), .wd_mode_cfg_i(mode), .sleep_i(sleep_i), .wake_clk_clears_i(1'b1),
    .osc_startup_timer_i(osc_startup_timer), .osc_fail_i(fail), .clear_watchdog_instr_i(clr), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reset_req_o(rq), .wake_o(wk),
    .timeout_flag_n_o(to_n), .powerdown_flag_n_o(pd_n), .wd_reset_cause_flag_o(cause), .irq_o(irq_o));
  // pulses last one cycle, so they are counted rather than polled
  always @(posedge clk_i) begin
    if (rq === 1'b1) rq_n <= rq_n + 1;
    if (wk === 1'b1) wk_n <= wk_n + 1;
  end
  task complete_run;
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
    @(posedge clk_i);
  endtask
  task cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    cycles(4);
    rst_n_i <= 1'b1;
    rd(`WD_ADDR_CTRL, d); cmp(d, 8'h16);
    rd(`WD_ADDR_STAT, d); cmp(d, 8'h1C);
    rd(`WD_ADDR_MASK, d); cmp(d, 8'h00);
    rd(4'h5, d); cmp(d, 8'h00);
    foreach (rows[i]) begin
      mode <= rows[i].m; sleep_i <= rows[i].slp; osc_startup_timer <= rows[i].osc_startup_timer; fail <= rows[i].fail;
      wr(`WD_ADDR_CTRL, {7'h00, rows[i].en});
      cycles(4);
      wr(`WD_ADDR_STAT, 8'h03);
      r0 = rq_n; w0 = wk_n;
      cycles(200);
      rd(`WD_ADDR_STAT, d); cmp(d & 8'h03, {6'h00, rows[i].exp});
      cmp({6'h00, wk_n != w0, rq_n != r0}, {6'h00, rows[i].exp});
    end
    fail <= 1'b0;
    cycles(4);
    wr(`WD_ADDR_STAT, 8'h03);
    repeat (6) begin
      cycles(60);
      clr <= 1'b1;
      cycles(1);
      clr <= 1'b0;
    end
    rd(`WD_ADDR_STAT, d); cmp(d & 8'h03, 8'h00);
    wr(`WD_ADDR_MASK, 8'h01);
    cycles(200);
    @(negedge clk_i) cmp({5'h00, irq_o, to_n, cause}, 8'h04);
    @(posedge clk_i);
    mode <= 2'b00;
    cycles(4);
    wr(`WD_ADDR_STAT, 8'h03);
    clr <= 1'b1;
    cycles(1);
    clr <= 1'b0;
    cycles(4);
    @(negedge clk_i) cmp({4'h0, irq_o, to_n, pd_n, cause}, 8'h06);
    @(posedge clk_i);
    mode <= 2'b11;
    wr(`WD_ADDR_CTRL, 8'h02);
    cycles(4);
    wr(`WD_ADDR_STAT, 8'h03);
    cycles(200);
    rd(`WD_ADDR_STAT, d); cmp(d & 8'h03, 8'h00);
    cycles(100);
    rd(`WD_ADDR_STAT, d); cmp(d & 8'h03, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire
